// [hdl/sdcd_top.sv]
`timescale 1ns/10ps
// How it works
// - Commands come only from pins sampled at edge.
// - Strobe patterns decode to access and stop commands.
// - Previous and current clock enable select power modes.
// - Bank state is judged on the selected bank.
// - Power-down during a burst becomes clock suspend.
// - Deselect with clock enable held high starts nothing, running bursts continue.
// - No-operation registers nothing, leaves operations alone.
// - Activate opens given row in given bank.
// - Burst length comes from programmed mode register.
// - Columns advance by sequence, wrapping inside block.
// - Full page uses sequential order only.
// - Full-page burst runs until burst stop, precharge or new access.
// - New access abandons burst and restarts full length.
// - Partial refresh leaves unselected banks unrefreshed.
// - Read takes bank, low ten column bits, auto-close.
// - Mode set with bank code two loads extended register.
// - Read latency is two or three clocks.
// - Precharge closes one bank, or all with A10.
module sdcd_top
	import sdcd_pkg::*;
(
	// Clock and reset.
	input wire logic I_CLK_SYS,
	input wire logic I_RST,
	// Command pins, active low strobes.
	input wire logic I_CS_N,
	input wire logic I_RAS_N,
	input wire logic I_CAS_N,
	input wire logic I_WE_N,
	input wire logic I_DQM,
	input wire logic I_CKE,
	input wire logic [1:0] I_BA,
	input wire logic [sdcd_pkg::SDCD_ADDR_W-1:0] I_ADDR,
	// Decoded command and bank state.
	output logic [3:0] O_CMD,
	output logic [3:0] O_BANK_OPEN,
	output logic [51:0] O_OPEN_ROWS,
	output logic [2:0] O_PWR_STATE,
	output logic O_NEED_INIT,
	// Burst progress.
	output logic O_BURST_ACTIVE,
	output logic O_BURST_WRITE,
	output logic [1:0] O_BURST_BANK,
	output logic [sdcd_pkg::SDCD_COL_W-1:0] O_COL,
	output logic O_DATA_EN,
	output logic O_READ_DATA_VALID,
	output logic O_AUTO_REFRESH,
	// Mode state.
	output logic [12:0] O_MODE,
	output logic [12:0] O_EMODE,
	output logic [3:0] O_SREF_BANKS
);
	import sdcd_pkg::*;

	// Two-stage synchronisers for every pin; only stage two is read.
	logic [23:0] pin_meta;
	logic [23:0] pin_sync;
	wire [23:0] pin_raw = {I_CS_N, I_RAS_N, I_CAS_N, I_WE_N, I_DQM, I_CKE,
		I_BA, I_ADDR, 3'h0};

	// Synchroniser stage one and two.
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			pin_meta <= 24'h000000;
			pin_sync <= 24'h000000;
		end else begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
		end
	end

	// Sampled levels; strobes are taken at the clock edge only.
	wire cs_n = pin_sync[23];
	wire ras_n = pin_sync[22];
	wire cas_n = pin_sync[21];
	wire we_n = pin_sync[20];
	wire dqm = pin_sync[19];
	wire cke = pin_sync[18];
	wire [1:0] ba = pin_sync[17:16];
	wire [12:0] addr = pin_sync[15:3];
	wire ap = addr[SDCD_AP_BIT];

	logic cke_prev; // Clock enable one edge before the command.
	sdcd_pwr_t pwr;
	logic [3:0] bank_open;
	logic [12:0] rows [4];
	logic [12:0] mode;
	logic [12:0] emode;
	logic burst;
	logic burst_wr;
	logic burst_ap;
	logic [1:0] burst_bank;
	logic [9:0] col_start;
	logic [9:0] beat;
	logic [2:0] rd_pipe; // Read latency shift line.
	logic need_init;

	// Strobe pattern decode; deselect with clock enable held high yields no command.
	wire [2:0] strb = {ras_n, cas_n, we_n};
	wire sel = ~cs_n;
	wire run = (pwr == SDCD_PWR_RUN);
	wire ck_hh = cke_prev & cke;
	wire ck_hl = cke_prev & ~cke; // Entry pair.
	wire ck_lh = ~cke_prev & cke; // Exit pair.
	wire idle_all = (bank_open == 4'h0) & ~burst;
	wire bank_is_open = bank_open[ba]; // Judged per selected bank.

	// Combinational command decode.
	sdcd_cmd_t next_cmd;
	always_comb begin
		next_cmd = SDCD_CMD_NONE;
		if (!run) begin
			if (ck_lh)
				next_cmd = SDCD_CMD_EXIT;
		end else if (ck_hl) begin
			// Power-down pattern during a burst suspends clock.
			if (burst)
				next_cmd = SDCD_CMD_SUSP;
			else if (sel && strb == 3'h1)
				next_cmd = SDCD_CMD_SREF;
			else if (sel && strb == 3'h6)
				next_cmd = SDCD_CMD_DPD;
			else if (!sel || strb == 3'h7)
				next_cmd = SDCD_CMD_PDN;
			else
				next_cmd = SDCD_CMD_SUSP;
		end else if (cke_prev && sel) begin
			case (strb)
				3'h3: next_cmd = bank_is_open ? SDCD_CMD_NONE : SDCD_CMD_ACT;
				3'h2: next_cmd = SDCD_CMD_PRE;
				3'h5: next_cmd = bank_is_open ? SDCD_CMD_READ : SDCD_CMD_NONE;
				3'h4: next_cmd = bank_is_open ? SDCD_CMD_WRITE : SDCD_CMD_NONE;
				3'h0: next_cmd = idle_all ? SDCD_CMD_MRS : SDCD_CMD_NONE;
				3'h7: next_cmd = SDCD_CMD_NOP; // Registers nothing.
				3'h6: next_cmd = SDCD_CMD_BST;
				3'h1: next_cmd = (ck_hh && idle_all) ? SDCD_CMD_AREF :
					SDCD_CMD_NONE;
				default: next_cmd = SDCD_CMD_NONE;
			endcase
		end
	end

	// Burst length in beats from mode field; full page never ends.
	wire [2:0] bl_code = mode[SDCD_BL_LSB +: 3];
	wire interleave = mode[SDCD_BT_BIT];
	wire full_page = (bl_code == SDCD_BL_FULL);
	wire [9:0] bl_mask = (bl_code == 3'h1) ? 10'h001 :
		(bl_code == 3'h2) ? 10'h003 :
		(bl_code == 3'h3) ? 10'h007 :
		full_page ? 10'h3FF : 10'h000;
	wire [9:0] next_beat = beat + 10'h001;
	wire burst_last = ~full_page & (beat == bl_mask);
	// Sequential adds, interleave xors inside the aligned block.
	// Full page always uses the sequential path.
	wire [9:0] offs = (interleave & ~full_page) ? (col_start ^ next_beat) :
		(col_start + next_beat);
	wire [9:0] next_col = (col_start & ~bl_mask) | (offs & bl_mask);
	// Read latency 2 or 3 from mode field.
	wire lat3 = (mode[SDCD_CL_LSB +: 3] == 3'h3);
	// Partial refresh bank set from extended mode field.
	wire [2:0] partial_refresh_select = emode[SDCD_PARTIAL_REFRESH_SELECT_LSB +: 3];
	wire [3:0] sref_banks = (partial_refresh_select == 3'h0) ? 4'hF :
		(partial_refresh_select == 3'h1) ? 4'h3 : 4'h1;
	wire is_access = (next_cmd == SDCD_CMD_READ) |
		(next_cmd == SDCD_CMD_WRITE);

	// Clock enable history and power state.
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			cke_prev <= 1'b0;
			pwr <= SDCD_PWR_RUN;
			need_init <= 1'b0;
		end else begin
			cke_prev <= cke;
			case (next_cmd)
				SDCD_CMD_SREF: pwr <= SDCD_PWR_SREF;
				SDCD_CMD_PDN: pwr <= SDCD_PWR_PDN;
				SDCD_CMD_SUSP: pwr <= SDCD_PWR_SUSP;
				SDCD_CMD_DPD: pwr <= SDCD_PWR_DPD;
				SDCD_CMD_EXIT: begin
					// Deep power-down exit flags a full re-init.
					if (pwr == SDCD_PWR_DPD)
						need_init <= 1'b1;
					pwr <= SDCD_PWR_RUN;
				end
				SDCD_CMD_MRS: need_init <= 1'b0;
				default: pwr <= pwr;
			endcase
		end
	end

	// Mode registers; bank code two selects the extended one.
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			mode <= SDCD_MODE_RST;
			emode <= SDCD_EMODE_RST;
		end else if (next_cmd == SDCD_CMD_MRS) begin
			if (ba == SDCD_EMR_BA)
				emode <= addr;
			else
				mode <= addr; // Taken with all banks idle.
		end
	end

	// Per-bank open flag and row, one slice per bank.
	genvar gb;
	generate
		for (gb = 0; gb < 4; gb++) begin : g_bank
			wire hit = (ba == 2'(gb));
			wire act = (next_cmd == SDCD_CMD_ACT) & hit;
			// A10 closes all banks, else only the addressed one.
			wire pre = (next_cmd == SDCD_CMD_PRE) & (ap | hit);
			// Auto-close fires at the last beat of this bank's burst.
			wire apc = burst & burst_ap & burst_last & ~is_access &
				(burst_bank == 2'(gb)) & run;
			always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
				if (I_RST) begin
					bank_open[gb] <= 1'b0;
					rows[gb] <= 13'h0000;
				end else if (act) begin
					bank_open[gb] <= 1'b1;
					rows[gb] <= addr;
				end else if (pre | apc) begin
					bank_open[gb] <= 1'b0;
				end
			end
			assign O_OPEN_ROWS[gb*13 +: 13] = rows[gb];
		end
	endgenerate

	// Burst engine; frozen while suspended, kept on deselect.
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			burst <= 1'b0;
			burst_wr <= 1'b0;
			burst_ap <= 1'b0;
			burst_bank <= 2'h0;
			col_start <= 10'h000;
			beat <= 10'h000;
			O_COL <= 10'h000;
		end else if (is_access) begin
			// New access restarts a full burst at the new column.
			burst <= 1'b1;
			burst_wr <= (next_cmd == SDCD_CMD_WRITE);
			burst_ap <= ap;
			burst_bank <= ba;
			col_start <= addr[SDCD_COL_W-1:0];
			beat <= 10'h000;
			O_COL <= addr[SDCD_COL_W-1:0];
		end else if (next_cmd == SDCD_CMD_BST ||
			(next_cmd == SDCD_CMD_PRE && (ap || ba == burst_bank))) begin
			burst <= 1'b0;
		end else if (burst && run) begin
			if (burst_last) begin
				burst <= 1'b0;
			end else begin
				beat <= next_beat;
				O_COL <= next_col;
			end
		end
	end

	// Output registers.
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			O_CMD <= 4'h0;
			O_DATA_EN <= 1'b0;
			rd_pipe <= 3'h0;
			O_READ_DATA_VALID <= 1'b0;
			O_AUTO_REFRESH <= 1'b0;
			O_SREF_BANKS <= 4'hF;
		end else begin
			O_CMD <= next_cmd;
			// Mask low enables data in an open bank.
			O_DATA_EN <= burst & ~dqm & bank_open[burst_bank];
			rd_pipe <= {rd_pipe[1:0], burst & ~burst_wr & ~dqm};
			O_READ_DATA_VALID <= lat3 ? rd_pipe[1] : rd_pipe[0];
			O_AUTO_REFRESH <= (next_cmd == SDCD_CMD_AREF);
			O_SREF_BANKS <= sref_banks; // Dropped banks lose data.
		end
	end

	assign O_BANK_OPEN = bank_open;
	assign O_PWR_STATE = pwr;
	assign O_NEED_INIT = need_init;
	assign O_BURST_ACTIVE = burst;
	assign O_BURST_WRITE = burst_wr;
	assign O_BURST_BANK = burst_bank;
	assign O_MODE = mode;
	assign O_EMODE = emode;
endmodule : sdcd_top

// [hdl/sdcd_pkg.sv]
package sdcd_pkg;
	// Command codes decoded from the sampled control pins.
	typedef enum logic [3:0] {
		SDCD_CMD_NONE = 4'h0,
		SDCD_CMD_ACT = 4'h1,
		SDCD_CMD_PRE = 4'h2,
		SDCD_CMD_READ = 4'h3,
		SDCD_CMD_WRITE = 4'h4,
		SDCD_CMD_MRS = 4'h5,
		SDCD_CMD_NOP = 4'h6,
		SDCD_CMD_BST = 4'h7,
		SDCD_CMD_AREF = 4'h8,
		SDCD_CMD_SREF = 4'h9,
		SDCD_CMD_PDN = 4'hA,
		SDCD_CMD_SUSP = 4'hB,
		SDCD_CMD_DPD = 4'hC,
		SDCD_CMD_EXIT = 4'hD
	} sdcd_cmd_t;

	// Power states of the device.
	typedef enum logic [2:0] {
		SDCD_PWR_RUN = 3'h0,
		SDCD_PWR_SREF = 3'h1,
		SDCD_PWR_PDN = 3'h2,
		SDCD_PWR_SUSP = 3'h3,
		SDCD_PWR_DPD = 3'h4
	} sdcd_pwr_t;

	// Address and mode field layout.
	localparam int SDCD_ADDR_W = 13;
	localparam int SDCD_COL_W = 10;
	localparam int SDCD_AP_BIT = 10;
	localparam int SDCD_BL_LSB = 0;
	localparam int SDCD_BT_BIT = 3;
	localparam int SDCD_CL_LSB = 4;
	localparam int SDCD_PARTIAL_REFRESH_SELECT_LSB = 0;
	localparam logic [1:0] SDCD_EMR_BA = 2'h2;
	localparam logic [2:0] SDCD_BL_FULL = 3'h7;
	// Reset values of the mode registers.
	localparam logic [12:0] SDCD_MODE_RST = 13'h0020;
	localparam logic [12:0] SDCD_EMODE_RST = 13'h0000;
endpackage : sdcd_pkg

// [tb/sdcd_monitor.sv]
`timescale 1ns/10ps
// Ties decoded activate, precharge-all, read, write and mode-set commands to the state that they leave behind.
module sdcd_monitor
	import sdcd_pkg::*;
(
	// Clock, reset and address pins.
	input wire logic I_CLK_SYS,
	input wire logic I_RST,
	input wire logic [sdcd_pkg::SDCD_ADDR_W-1:0] I_ADDR,
	// Observed device outputs.
	input wire logic [3:0] O_CMD,
	input wire logic [3:0] O_BANK_OPEN,
	input wire logic [2:0] O_PWR_STATE,
	input wire logic O_NEED_INIT,
	input wire logic O_BURST_ACTIVE,
	input wire logic O_BURST_WRITE,
	input wire logic [sdcd_pkg::SDCD_COL_W-1:0] O_COL,
	input wire logic O_DATA_EN,
	input wire logic [12:0] O_EMODE,
	input wire logic [3:0] O_SREF_BANKS
);
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (I_RST);
	// Pins reach the decode three edges late, so addresses are looked
	// up three samples back.
	sequence dpd_exit_s;
		$past(O_PWR_STATE) == SDCD_PWR_DPD ##0 O_PWR_STATE == SDCD_PWR_RUN;
	endsequence
	act_opens_a: assert property (O_CMD == SDCD_CMD_ACT |->
		O_BANK_OPEN != $past(O_BANK_OPEN)) else $error("activate ignored");
	pre_all_a: assert property (O_CMD == SDCD_CMD_PRE &&
		$past(I_ADDR[SDCD_AP_BIT], 3) |-> O_BANK_OPEN == 4'h0)
		else $error("precharge all left a bank open");
	read_col_a: assert property (O_CMD == SDCD_CMD_READ |->
		O_COL == $past(I_ADDR[9:0], 3)) else $error("bad start column");
	read_dir_a: assert property (O_CMD == SDCD_CMD_READ |->
		O_BURST_ACTIVE && !O_BURST_WRITE) else $error("read not started");
	write_dir_a: assert property (O_CMD == SDCD_CMD_WRITE |->
		O_BURST_ACTIVE && O_BURST_WRITE) else $error("write not started");
	init_clear_a: assert property (O_CMD == SDCD_CMD_MRS |->
		!O_NEED_INIT) else $error("mode set kept init flag");
	init_set_a: assert property (dpd_exit_s |-> O_NEED_INIT)
		else $error("deep power-down exit without init flag");
	no_pdn_burst_a: assert property (O_BURST_ACTIVE |->
		O_PWR_STATE != SDCD_PWR_PDN) else $error("power-down in burst");
	data_en_a: assert property (O_DATA_EN |->
		$past(O_BURST_ACTIVE) && $past(|O_BANK_OPEN))
		else $error("data enabled outside a burst");
	partial_refresh_select_map_a: assert property (O_EMODE[2:0] == 3'h1 |->
		##[0:1] O_SREF_BANKS == 4'h3) else $error("bad refresh bank set");
endmodule : sdcd_monitor

// [tb/sdcd_ctrl_model.sv]
`timescale 1ns/10ps
// Memory controller model; it changes pins only after a falling edge.
module sdcd_ctrl_model (
	// Clock.
	input wire logic i_clk,
	// Command pins toward the device.
	output logic [3:0] o_cmd_n,
	output logic o_dqm,
	output logic o_cke,
	output logic [1:0] o_ba,
	output logic [12:0] o_addr
);
	// Deselected with clock enable high until the first call.
	initial begin
		o_cmd_n = 4'hF;
		o_dqm = 1'b0;
		o_cke = 1'b1;
		o_ba = 2'h0;
		o_addr = 13'h0000;
	end
	// Holds the pin set until the next call, so it is steady at the edge.
	task automatic issue(input logic [3:0] c, input logic [1:0] b,
		input logic [12:0] a, input logic k, input logic m);
		@(negedge i_clk);
		o_cmd_n = c;
		o_ba = b;
		o_addr = a;
		o_cke = k;
		o_dqm = m;
	endtask : issue
endmodule : sdcd_ctrl_model

// [tb/sdcd_top_tb_top.sv]
`timescale 1ns/10ps
// Self-checking bench: command sequences with expected outcomes.
module sdcd_top_tb_top;
	import sdcd_pkg::*;
	// Clock, reset and pins.
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] c_n, ocmd, bopen, sref;
	logic dqm, cke, ninit, bact, bwr, den, rdv, aref;
	logic [1:0] ba, bbank;
	logic [12:0] addr, mode, emode;
	logic [51:0] rows;
	logic [2:0] pwr;
	logic [9:0] col;
	int n_mismatch = 0;
	int checks = 0;
	int i;
	// Patterns with clock enable low and the power state each enters.
	logic [3:0] pat [3] = '{4'h1, 4'h7, 4'h6};
	logic [2:0] pst [3] = '{SDCD_PWR_SREF, SDCD_PWR_PDN, SDCD_PWR_DPD};
	// Eight-word interleaved order for a start column of two.
	logic [9:0] ilv [8] = '{10'h002, 10'h003, 10'h000, 10'h001,
		10'h006, 10'h007, 10'h004, 10'h005};
	always #50 clk = ~clk;
	sdcd_ctrl_model sdcd_ctrl_model_inst (.i_clk(clk), .o_cmd_n(c_n),
		.o_dqm(dqm), .o_cke(cke), .o_ba(ba), .o_addr(addr));
	sdcd_top sdcd_top_inst (.I_CLK_SYS(clk), .I_RST(rst), .I_CS_N(c_n[3]),
		.I_RAS_N(c_n[2]), .I_CAS_N(c_n[1]), .I_WE_N(c_n[0]), .I_DQM(dqm),
		.I_CKE(cke), .I_BA(ba), .I_ADDR(addr), .O_CMD(ocmd),
		.O_BANK_OPEN(bopen), .O_OPEN_ROWS(rows), .O_PWR_STATE(pwr),
		.O_NEED_INIT(ninit), .O_BURST_ACTIVE(bact), .O_BURST_WRITE(bwr),
		.O_BURST_BANK(bbank), .O_COL(col), .O_DATA_EN(den),
		.O_READ_DATA_VALID(rdv), .O_AUTO_REFRESH(aref), .O_MODE(mode),
		.O_EMODE(emode),
		.O_SREF_BANKS(sref));
	// Reports a mismatch at once; an unknown matches only an unknown in the same bit of the expected value.
	task automatic chk(input string n, input logic [63:0] s, e);
		checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %0h seen %0h", n, e, s);
		end
	endtask : chk
	task automatic iss(input logic [3:0] c, input logic [1:0] b,
		input logic [12:0] a, input logic k, input logic m);
		sdcd_ctrl_model_inst.issue(c, b, a, k, m);
	endtask : iss
	// One-cycle command, then a no-operation with the address turned
	// round; returns in the cycle where the decode stands.
	task automatic cmd(input logic [3:0] c, input logic [1:0] b,
		input logic [12:0] a);
		iss(c, b, a, 1'b1, 1'b0);
		iss(4'h7, b, ~a, 1'b1, 1'b0);
		repeat (2) @(negedge clk);
	endtask : cmd
	task automatic close_out;
		$display("Mismatches %0d, checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out
	// Main sequence.
	initial begin
		repeat (5) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		chk("mode", mode, 13'h0020);
		chk("sref", sref, 4'hF);
		chk("refresh", aref, 1'b0);
		cmd(4'h0, 2'h0, 13'h0022);
		chk("mode", mode, 13'h0022);
		cmd(4'h0, 2'h2, 13'h0001);
		chk("emode", emode, 13'h0001);
		@(negedge clk);
		chk("sref", sref, 4'h3);
		cmd(4'h3, 2'h1, 13'h0123);
		chk("open", bopen, 4'h2);
		chk("row", rows[25:13], 13'h0123);
		// A second activate to an open bank is refused.
		cmd(4'h3, 2'h1, 13'h0055);
		chk("cmd", ocmd, SDCD_CMD_NONE);
		chk("row", rows[25:13], 13'h0123);
		cmd(4'h5, 2'h0, 13'h0000);
		chk("cmd", ocmd, SDCD_CMD_NONE);
		cmd(4'h5, 2'h1, 13'h000E);
		chk("write", bwr, 1'b0);
		for (i = 0; i < 4; i++) begin
			chk("col", col, 10'h00C | ((i + 2) % 4));
			chk("bank", bbank, 2'h1);
			chk("data en", den, i >= 1);
			chk("valid", rdv, i >= 2);
			@(negedge clk);
		end
		chk("burst", bact, 1'b0);
		// Read cut by a masked write, then a deselect mid-burst.
		iss(4'h5, 2'h1, 13'h0010, 1'b1, 1'b0);
		iss(4'h4, 2'h1, 13'h0025, 1'b1, 1'b1);
		iss(4'hF, 2'h1, 13'h1FDA, 1'b1, 1'b0);
		iss(4'h7, 2'h1, 13'h0025, 1'b1, 1'b0);
		@(negedge clk);
		chk("cmd", ocmd, SDCD_CMD_WRITE);
		chk("col", col, 10'h025);
		chk("write", bwr, 1'b1);
		chk("data en", den, 1'b0);
		@(negedge clk);
		chk("cmd", ocmd, SDCD_CMD_NONE);
		chk("col", col, 10'h026);
		chk("data en", den, 1'b1);
		chk("valid", rdv, 1'b0);
		repeat (4) @(negedge clk);
		cmd(4'h3, 2'h0, 13'h0007);
		cmd(4'h2, 2'h1, 13'h0000);
		chk("open", bopen, 4'h1);
		cmd(4'h2, 2'h1, 13'h0400);
		chk("open", bopen, 4'h0);
		cmd(4'h1, 2'h0, 13'h0000);
		chk("cmd", ocmd, SDCD_CMD_AREF);
		chk("refresh", aref, 1'b1);
		// Eight-word interleaved read with a read latency of three.
		cmd(4'h0, 2'h0, 13'h003B);
		chk("mode", mode, 13'h003B);
		cmd(4'h3, 2'h2, 13'h0100);
		cmd(4'h5, 2'h2, 13'h0002);
		for (i = 0; i < 8; i++) begin
			chk("col", col, ilv[i]);
			chk("valid", rdv, i >= 3);
			@(negedge clk);
		end
		chk("burst", bact, 1'b0);
		// Full page asked with interleave still counts up and runs on.
		cmd(4'h2, 2'h0, 13'h0400);
		cmd(4'h0, 2'h0, 13'h002F);
		cmd(4'h3, 2'h0, 13'h0010);
		cmd(4'h5, 2'h0, 13'h03FE);
		for (i = 0; i < 4; i++) begin
			chk("col", col, (i + 1022) % 1024);
			@(negedge clk);
		end
		chk("burst", bact, 1'b1);
		cmd(4'h6, 2'h0, 13'h0000);
		chk("cmd", ocmd, SDCD_CMD_BST);
		chk("burst", bact, 1'b0);
		// Power-down asked during a burst suspends the clock instead.
		cmd(4'h3, 2'h3, 13'h0001);
		iss(4'h5, 2'h3, 13'h0000, 1'b1, 1'b0);
		repeat (3) iss(4'h7, 2'h3, 13'h0000, 1'b0, 1'b0);
		@(negedge clk);
		chk("power", pwr, SDCD_PWR_SUSP);
		iss(4'h7, 2'h3, 13'h0000, 1'b1, 1'b0);
		repeat (8) @(negedge clk);
		chk("power", pwr, SDCD_PWR_RUN);
		cmd(4'h2, 2'h0, 13'h0400);
		for (i = 0; i < 3; i++) begin
			iss(pat[i], 2'h0, 13'h0000, 1'b0, 1'b0);
			repeat (2) iss(4'h7, 2'h0, 13'h0000, 1'b0, 1'b0);
			@(negedge clk);
			chk("power", pwr, pst[i]);
			iss(4'h7, 2'h0, 13'h0000, 1'b1, 1'b0);
			repeat (5) @(negedge clk);
			chk("power", pwr, SDCD_PWR_RUN);
		end
		chk("init", ninit, 1'b1);
		cmd(4'h0, 2'h0, 13'h0022);
		chk("init", ninit, 1'b0);
		close_out();
	end
endmodule : sdcd_top_tb_top
bind sdcd_top sdcd_monitor sdcd_monitor_inst (.I_CLK_SYS(I_CLK_SYS),
	.I_RST(I_RST), .I_ADDR(I_ADDR), .O_CMD(O_CMD),
	.O_BANK_OPEN(O_BANK_OPEN), .O_PWR_STATE(O_PWR_STATE),
	.O_NEED_INIT(O_NEED_INIT), .O_BURST_ACTIVE(O_BURST_ACTIVE),
	.O_BURST_WRITE(O_BURST_WRITE), .O_COL(O_COL), .O_DATA_EN(O_DATA_EN),
	.O_EMODE(O_EMODE), .O_SREF_BANKS(O_SREF_BANKS));
